// ---- rtl/fault_sleep_ctrl.sv ----
// Fault classification, escalation, lockup and sleep/wakeup controller
// What this block does
// - Vector read bus error: hard fault, flag
// - Escalated fault: hard fault, escalation flag
// - Protection faults flagged; never-execute flags fetch
// - Bus faults flagged per stacking, prefetch, data
// - Usage faults each get their own flag
// - Faults have programmable priority and enables
// - Same fault inside its handler escalates
// - Fault not above current priority escalates
// - Fault with disabled handler escalates
// - Bus stacking error entering bus handler stays
// - Hard fault preempted only by reset, NMI
// - Status flags record causes; addresses captured
// - Hard fault inside hard handler: lockup till reset
// - Deep-sleep select chooses the sleep mode
// - Wait-for-interrupt sleeps at once
// - Wait-for-event consumes event or sleeps
// - Sleep-after-handler sleeps on return to thread
// - Interrupt sleep wakes on sufficient priority exception
// - Primary mask set: wake, hold handler
// - Event-on-pending: new pending wakes event sleep
// - Spurious wake from debug is allowed
// - Sufficient priority must beat mask limits
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fault_sleep_ctrl
    import fault_sleep_pkg::*;
#(
    parameter int PRIO_W = 8 // Priority width, lower value is more urgent
) (
    input wire logic clk_i, // Core clock 50 MHz
    input wire logic rst_i, // Synchronous active-high reset
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pipeline side
    input wire fault_cause_s cause_i,      // Fault causes, one-cycle pulses
    input wire logic [31:0] fault_addr_i,  // Address of the faulting access
    input wire logic fault_addr_ok_i,      // Address is meaningful
    input wire logic handler_mode_i,       // Core runs a handler
    input wire logic in_hard_handler_i,    // Current handler is hard fault
    input wire logic [PRIO_W-1:0] exec_prio_i, // Current execution priority
    input wire logic wfi_i,                // wait_interrupt_instr executes
    input wire logic wfe_i,                // wait_event_instr executes
    input wire logic handler_exit_i,       // Return to thread mode completes
    input wire logic debug_wake_i,         // Debug operation wake
    // Interrupt controller side
    input wire logic [PRIO_W-1:0] pend_prio_i, // Best pending enabled priority
    input wire logic pend_valid_i,         // An enabled exception is pending
    input wire logic new_pend_i,           // Any interrupt newly pending, pulse
    input wire logic [PRIO_W-1:0] mask_level_i, // Priority limit of base mask, 0 = off
    input wire logic primary_interrupt_mask_i,
    input wire logic fault_level_mask_i,
    input wire logic send_event_i,         // External event signal, pulse
    // Outputs
    output fault_take_s take_o,            // Fault taken
    output logic lockup_o,                 // Locked, no execution
    output logic sleeping_o,               // Core asleep
    output logic deep_sleep_o,             // Sleep is deep
    output logic run_handler_o             // Wake may dispatch handler
);
    // Priority width sanity
    if (PRIO_W < 1 || PRIO_W > 8) begin : g_chk
        $error("PRIO_W must be 1..8");
    end

    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP_WFI, PWR_SLEEP_WFE} pwr_e;

    // Status and control registers
    logic [31:0] hard_fault_status_reg_q;
    logic [7:0] protection_fault_status_reg_q;
    logic [31:0] protection_fault_addr_reg_q;
    logic [7:0] bus_fault_status_reg_q;
    logic [31:0] bus_fault_addr_reg_q;
    logic [15:0] usage_fault_status_reg_q;
    logic [31:0] system_control_reg_q;
    logic [31:0] fault_cfg_q;
    logic lockup_q; // Stuck until reset
    logic event_q; // One-bit event latch
    pwr_e pwr_q;
    fault_take_s take_q;
    logic run_handler_q;
    logic [31:0] rdata_q;
    logic ack_q;

    // Bus write strobe; one-cycle ack so a write lands once
    logic wr_en;
    logic rd_en;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

    // Byte-lane merge, used by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Write-one-to-clear mask for a status register
    function automatic logic [31:0] w1c(input logic hit, input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        if (hit) begin
            m = merge(32'h0000_0000, d, sel);
        end
        return m;
    endfunction

    // Fault class decoding
    logic any_prot, any_bus, any_usage, any_cfg;
    assign any_prot = cause_i.prot_instr | cause_i.prot_data | cause_i.prot_stack | cause_i.prot_unstack;
    assign any_bus = cause_i.bus_stack | cause_i.bus_unstack | cause_i.bus_prefetch
        | cause_i.bus_exact | cause_i.bus_inexact;
    assign any_usage = cause_i.coprocessor | cause_i.undef_op | cause_i.bad_isa
        | cause_i.bad_return | cause_i.unaligned | cause_i.zero_div;
    assign any_cfg = any_prot | any_bus | any_usage;

    // Class picked when several causes coincide: protection, bus, usage
    fault_class_e cfg_cls;
    logic [PRIO_W-1:0] cfg_prio;
    logic cfg_en;
    always_comb begin
        cfg_cls = CLS_USAGE;
        cfg_prio = fault_cfg_q[CFG_USAGE_PRIO_LSB +: PRIO_W];
        cfg_en = fault_cfg_q[CFG_USAGE_EN_BIT];
        if (any_prot) begin
            cfg_cls = CLS_PROT;
            cfg_prio = fault_cfg_q[CFG_PROT_PRIO_LSB +: PRIO_W];
            cfg_en = fault_cfg_q[CFG_PROT_EN_BIT];
        end else if (any_bus) begin
            cfg_cls = CLS_BUS;
            cfg_prio = fault_cfg_q[CFG_BUS_PRIO_LSB +: PRIO_W];
            cfg_en = fault_cfg_q[CFG_BUS_EN_BIT];
        end
    end

    // Bus stacking error entering bus handler keeps bus class
    logic bus_entry_stack;
    assign bus_entry_stack = (cfg_cls == CLS_BUS) && cause_i.bus_stack && cfg_en;

    // Escalation: disabled handler, or not above current priority
    logic escalate;
    assign escalate = any_cfg && !bus_entry_stack && (!cfg_en
        || (handler_mode_i && cfg_prio >= exec_prio_i));
    logic hard_now;
    assign hard_now = cause_i.vector_read || escalate;

    // Hard status: vector read and escalation flags, set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hard_fault_status_reg_q <= '0;
        end else begin
            hard_fault_status_reg_q <= hard_fault_status_reg_q
                & ~w1c(wr_en && wb_adr_i == OFS_HARD_STATUS, wb_dat_i, wb_sel_i);
            if (cause_i.vector_read) begin
                hard_fault_status_reg_q[HF_VECTOR_BIT] <= 1'b1;
            end
            if (escalate) begin
                hard_fault_status_reg_q[HF_ESCAL_BIT] <= 1'b1;
            end
        end
    end

    // Protection status and address capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protection_fault_status_reg_q <= '0;
            protection_fault_addr_reg_q <= '0;
        end else begin
            protection_fault_status_reg_q <= protection_fault_status_reg_q
                & ~8'(w1c(wr_en && wb_adr_i == OFS_PROT_STATUS, wb_dat_i, wb_sel_i));
            if (cause_i.prot_instr) protection_fault_status_reg_q[PF_INSTR_BIT] <= 1'b1;
            if (cause_i.prot_data) protection_fault_status_reg_q[PF_DATA_BIT] <= 1'b1;
            if (cause_i.prot_stack) protection_fault_status_reg_q[PF_STACK_BIT] <= 1'b1;
            if (cause_i.prot_unstack) protection_fault_status_reg_q[PF_UNSTACK_BIT] <= 1'b1;
            // Only data accesses carry a useful address
            if (cause_i.prot_data && fault_addr_ok_i) begin
                protection_fault_addr_reg_q <= fault_addr_i;
                protection_fault_status_reg_q[PF_ADDR_VALID_BIT] <= 1'b1;
            end
        end
    end

    // Bus status and address capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_fault_status_reg_q <= '0;
            bus_fault_addr_reg_q <= '0;
        end else begin
            bus_fault_status_reg_q <= bus_fault_status_reg_q
                & ~8'(w1c(wr_en && wb_adr_i == OFS_BUS_STATUS, wb_dat_i, wb_sel_i));
            if (cause_i.bus_stack) bus_fault_status_reg_q[BF_STACK_BIT] <= 1'b1;
            if (cause_i.bus_unstack) bus_fault_status_reg_q[BF_UNSTACK_BIT] <= 1'b1;
            if (cause_i.bus_prefetch) bus_fault_status_reg_q[BF_PREFETCH_BIT] <= 1'b1;
            if (cause_i.bus_exact) bus_fault_status_reg_q[BF_EXACT_BIT] <= 1'b1;
            if (cause_i.bus_inexact) bus_fault_status_reg_q[BF_INEXACT_BIT] <= 1'b1;
            // Imprecise errors lose their address, so only precise ones load
            if (cause_i.bus_exact && fault_addr_ok_i) begin
                bus_fault_addr_reg_q <= fault_addr_i;
                bus_fault_status_reg_q[BF_ADDR_VALID_BIT] <= 1'b1;
            end
        end
    end

    // Usage status flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            usage_fault_status_reg_q <= '0;
        end else begin
            usage_fault_status_reg_q <= usage_fault_status_reg_q
                & ~16'(w1c(wr_en && wb_adr_i == OFS_USAGE_STATUS, wb_dat_i, wb_sel_i));
            if (cause_i.coprocessor) usage_fault_status_reg_q[UF_COPROC_BIT] <= 1'b1;
            if (cause_i.undef_op) usage_fault_status_reg_q[UF_UNDEF_BIT] <= 1'b1;
            if (cause_i.bad_isa) usage_fault_status_reg_q[UF_ISA_BIT] <= 1'b1;
            if (cause_i.bad_return) usage_fault_status_reg_q[UF_RETURN_BIT] <= 1'b1;
            if (cause_i.unaligned) usage_fault_status_reg_q[UF_UNALIGN_BIT] <= 1'b1;
            if (cause_i.zero_div) usage_fault_status_reg_q[UF_ZERODIV_BIT] <= 1'b1;
        end
    end

    // Control registers written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_control_reg_q <= SYS_CTRL_RST;
            fault_cfg_q <= FAULT_CFG_RST;
        end else if (wr_en) begin
            if (wb_adr_i == OFS_SYS_CTRL) system_control_reg_q <= merge(system_control_reg_q, wb_dat_i, wb_sel_i);
            if (wb_adr_i == OFS_FAULT_CFG) fault_cfg_q <= merge(fault_cfg_q, wb_dat_i, wb_sel_i);
        end
    end

    // Fault take pulse and lockup; hard fault wins over all but reset/NMI
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            take_q <= '0;
            lockup_q <= 1'b0;
        end else begin
            take_q <= '0;
            if (hard_now && in_hard_handler_i) begin
                lockup_q <= 1'b1;
            end else if (!lockup_q && hard_now) begin
                take_q <= '{valid: 1'b1, cls: CLS_HARD, escalated: escalate};
            end else if (!lockup_q && any_cfg) begin
                take_q <= '{valid: 1'b1, cls: cfg_cls, escalated: 1'b0};
            end
        end
    end

    // Sufficient priority: beats current level, fault mask and base mask limit
    logic sufficient;
    assign sufficient = pend_valid_i && !fault_level_mask_i
        && (!handler_mode_i || pend_prio_i < exec_prio_i)
        && (mask_level_i == '0 || pend_prio_i < mask_level_i);
    // Wake on priority without the primary mask, which only holds dispatch
    logic prio_wake;
    // Base mask limit still applies, or a masked level would wake us
    assign prio_wake = pend_valid_i && !fault_level_mask_i
        && (!handler_mode_i || pend_prio_i < exec_prio_i)
        && (mask_level_i == '0 || pend_prio_i < mask_level_i);

    // Power state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_q <= PWR_RUN;
            event_q <= 1'b0;
            run_handler_q <= 1'b0;
        end else begin
            run_handler_q <= 1'b0;
            if (send_event_i || (system_control_reg_q[SC_EVENT_PEND_BIT] && new_pend_i)) begin
                event_q <= 1'b1;
            end
            case (pwr_q)
                PWR_RUN: begin
                    // Lockup blocks all instruction effects
                    if (lockup_q) begin
                        pwr_q <= PWR_RUN;
                    end else if (wfi_i) begin
                        pwr_q <= PWR_SLEEP_WFI;
                    end else if (wfe_i) begin
                        if (event_q) begin
                            event_q <= 1'b0;
                        end else begin
                            pwr_q <= PWR_SLEEP_WFE;
                        end
                    end else if (handler_exit_i && system_control_reg_q[SC_SLEEP_EXIT_BIT]) begin
                        pwr_q <= PWR_SLEEP_WFI;
                    end
                end
                PWR_SLEEP_WFI: begin
                    // Debug may wake us spuriously; software re-sleeps
                    if (prio_wake || debug_wake_i) begin
                        pwr_q <= PWR_RUN;
                        run_handler_q <= sufficient && !primary_interrupt_mask_i;
                    end
                end
                PWR_SLEEP_WFE: begin
                    if (sufficient || event_q || debug_wake_i) begin
                        pwr_q <= PWR_RUN;
                        event_q <= 1'b0;
                        run_handler_q <= sufficient && !primary_interrupt_mask_i;
                    end
                end
                default: pwr_q <= PWR_RUN;
            endcase
        end
    end

    // Register read mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (rd_en) begin
                case (wb_adr_i)
                    OFS_HARD_STATUS: rdata_q <= hard_fault_status_reg_q;
                    OFS_PROT_STATUS: rdata_q <= {24'h00_0000, protection_fault_status_reg_q};
                    OFS_PROT_ADDR: rdata_q <= protection_fault_addr_reg_q;
                    OFS_BUS_STATUS: rdata_q <= {24'h00_0000, bus_fault_status_reg_q};
                    OFS_BUS_ADDR: rdata_q <= bus_fault_addr_reg_q;
                    OFS_USAGE_STATUS: rdata_q <= {16'h0000, usage_fault_status_reg_q};
                    OFS_SYS_CTRL: rdata_q <= system_control_reg_q;
                    OFS_FAULT_CFG: rdata_q <= fault_cfg_q;
                    OFS_CORE_STATE: rdata_q <= {28'h000_0000, event_q, pwr_q != PWR_RUN, lockup_q, 1'b0};
                    default: rdata_q <= 32'h0000_0000; // Unmapped reads zero
                endcase
            end
        end
    end

    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign take_o = take_q;
    assign lockup_o = lockup_q;
    assign sleeping_o = (pwr_q != PWR_RUN);
    assign deep_sleep_o = system_control_reg_q[SC_DEEP_BIT];
    assign run_handler_o = run_handler_q;

    // Checks
    property p_vec_hard;
        @(posedge clk_i) disable iff (rst_i)
        cause_i.vector_read && !in_hard_handler_i && !lockup_q |=> take_q.valid && take_q.cls == CLS_HARD
            && hard_fault_status_reg_q[HF_VECTOR_BIT];
    endproperty
    a_vec_hard: assert property (p_vec_hard) else $error("vector error not hard");
    property p_escal;
        @(posedge clk_i) disable iff (rst_i)
        any_cfg && !cfg_en && !bus_entry_stack |=> hard_fault_status_reg_q[HF_ESCAL_BIT];
    endproperty
    a_escal: assert property (p_escal) else $error("disabled fault not escalated");
    property p_zero_div;
        @(posedge clk_i) disable iff (rst_i) cause_i.zero_div |=> usage_fault_status_reg_q[UF_ZERODIV_BIT];
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("zero divide flag missing");
    property p_lock;
        @(posedge clk_i) disable iff (rst_i) lockup_q |=> lockup_q && !take_q.valid;
    endproperty
    a_lock: assert property (p_lock) else $error("lockup left");
    property p_wfi;
        @(posedge clk_i) disable iff (rst_i)
        pwr_q == PWR_RUN && !lockup_q && wfi_i |=> pwr_q == PWR_SLEEP_WFI;
    endproperty
    a_wfi: assert property (p_wfi) else $error("wfi did not sleep");
    property p_wfe_event;
        @(posedge clk_i) disable iff (rst_i)
        pwr_q == PWR_RUN && !lockup_q && !wfi_i && wfe_i && event_q && !send_event_i && !new_pend_i
            |=> pwr_q == PWR_RUN && !event_q;
    endproperty
    a_wfe_event: assert property (p_wfe_event) else $error("event not consumed");
    property p_mask_hold;
        @(posedge clk_i) disable iff (rst_i)
        pwr_q == PWR_SLEEP_WFI && primary_interrupt_mask_i |=> !run_handler_q;
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("handler ran under mask");
    property p_bus_stack;
        @(posedge clk_i) disable iff (rst_i)
        cause_i == fault_cause_s'(1) << 10 && fault_cfg_q[CFG_BUS_EN_BIT] && !lockup_q
            |=> take_q.valid && take_q.cls == CLS_BUS;
    endproperty
    a_bus_stack: assert property (p_bus_stack) else $error("bus stacking escalated");
    c_lock: cover property (@(posedge clk_i) disable iff (rst_i) $rose(lockup_q));
    c_wfe: cover property (@(posedge clk_i) disable iff (rst_i) pwr_q == PWR_SLEEP_WFE ##1 pwr_q == PWR_RUN);
    c_esc: cover property (@(posedge clk_i) disable iff (rst_i) take_q.valid && take_q.escalated);
endmodule
`default_nettype wire

// ---- rtl/fault_sleep_pkg.sv ----
// Package: register map, field positions, reset values and carriers for the fault/sleep block
package fault_sleep_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] OFS_HARD_STATUS = 8'h00; // hard_fault_status_reg
    localparam logic [7:0] OFS_PROT_STATUS = 8'h04; // protection_fault_status_reg
    localparam logic [7:0] OFS_PROT_ADDR = 8'h08; // protection_fault_addr_reg
    localparam logic [7:0] OFS_BUS_STATUS = 8'h0c; // bus_fault_status_reg
    localparam logic [7:0] OFS_BUS_ADDR = 8'h10; // bus_fault_addr_reg
    localparam logic [7:0] OFS_USAGE_STATUS = 8'h14; // usage_fault_status_reg
    localparam logic [7:0] OFS_SYS_CTRL = 8'h18; // system_control_reg
    localparam logic [7:0] OFS_FAULT_CFG = 8'h1c; // Priorities and handler enables
    localparam logic [7:0] OFS_CORE_STATE = 8'h20; // Event latch, sleep, lockup

    // Hard status bit positions
    localparam int HF_VECTOR_BIT = 1;
    localparam int HF_ESCAL_BIT = 30;
    // Protection status bit positions
    localparam int PF_INSTR_BIT = 0;
    localparam int PF_DATA_BIT = 1;
    localparam int PF_UNSTACK_BIT = 3;
    localparam int PF_STACK_BIT = 4;
    localparam int PF_ADDR_VALID_BIT = 7;
    // Bus status bit positions
    localparam int BF_PREFETCH_BIT = 0;
    localparam int BF_EXACT_BIT = 1;
    localparam int BF_INEXACT_BIT = 2;
    localparam int BF_UNSTACK_BIT = 3;
    localparam int BF_STACK_BIT = 4;
    localparam int BF_ADDR_VALID_BIT = 7;
    // Usage status bit positions
    localparam int UF_UNDEF_BIT = 0;
    localparam int UF_ISA_BIT = 1;
    localparam int UF_RETURN_BIT = 2;
    localparam int UF_COPROC_BIT = 3;
    localparam int UF_UNALIGN_BIT = 8;
    localparam int UF_ZERODIV_BIT = 9;
    // System control bit positions
    localparam int SC_SLEEP_EXIT_BIT = 1;
    localparam int SC_DEEP_BIT = 2;
    localparam int SC_EVENT_PEND_BIT = 4;
    // Fault config fields: three priorities then three enables
    localparam int CFG_PROT_PRIO_LSB = 0;
    localparam int CFG_BUS_PRIO_LSB = 8;
    localparam int CFG_USAGE_PRIO_LSB = 16;
    localparam int CFG_PROT_EN_BIT = 24;
    localparam int CFG_BUS_EN_BIT = 25;
    localparam int CFG_USAGE_EN_BIT = 26;
    // Reset values
    localparam logic [31:0] SYS_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FAULT_CFG_RST = 32'h0000_0000;

    // Fault classes, encoded 0 to 3; the value is not an urgency level
    typedef enum logic [1:0] {CLS_PROT, CLS_BUS, CLS_USAGE, CLS_HARD} fault_class_e;

    // Error causes reported by the pipeline, one cycle pulses
    typedef struct packed {
        logic vector_read;     // Bus error fetching a vector
        logic prot_instr;      // Protection mismatch on fetch, or execute_never_region
        logic prot_data;       // Protection mismatch on data
        logic prot_stack;      // Protection mismatch while stacking
        logic prot_unstack;    // Protection mismatch while unstacking
        logic bus_stack;       // Bus error while stacking
        logic bus_unstack;     // Bus error while unstacking
        logic bus_prefetch;    // Bus error on prefetch
        logic bus_exact;       // Precise data bus error
        logic bus_inexact;     // Imprecise data bus error
        logic coprocessor;     // Coprocessor access
        logic undef_op;        // Undefined instruction
        logic bad_isa;         // Unsupported instruction-set state
        logic bad_return;      // Bad handler_return_code
        logic unaligned;       // Illegal unaligned access
        logic zero_div;        // Division by zero
    } fault_cause_s;

    // Outcome of one fault, toward the pipeline
    typedef struct packed {
        logic valid;           // A fault is taken this cycle
        fault_class_e cls;     // Handler that will run
        logic escalated;       // Raised to hard fault
    } fault_take_s;
endpackage

// ---- verification/fault_escalation_sleep_control_tb.sv ----
// Self-checking bench for the fault and sleep controller
`timescale 1ns/10ps
`default_nettype none
module fault_escalation_sleep_control_tb;
    import fault_sleep_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, go = 0, hm = 0, hh = 0, pv = 0, pm = 0, fm = 0;
    logic [7:0] adr = '0, pp = '0, ml = '0, ep = '1; // Bus address, pend/mask/exec levels
    logic [31:0] dat = '0, dout, rdata, addr = '0;
    logic [3:0] idx = '0;
    logic [5:0] ev = '0; // wfi, wfe, event, new pend, debug, handler exit
    logic ack, lock, slp, deep, rh;
    fault_take_s tk;
    fault_cause_s cz;
    integer seed = 32'h0d19347b;
    int fail_count = 0, n_checks = 0, cyc_cnt = 0;
    // Model: status register and bit for each cause index
    logic [7:0] offs[16] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0c,
        8'h04, 8'h04, 8'h04, 8'h04, 8'h00};
    int bits[16] = '{UF_ZERODIV_BIT, UF_UNALIGN_BIT, UF_RETURN_BIT, UF_ISA_BIT, UF_UNDEF_BIT, UF_COPROC_BIT,
        BF_INEXACT_BIT, BF_EXACT_BIT, BF_PREFETCH_BIT, BF_UNSTACK_BIT, BF_STACK_BIT, PF_UNSTACK_BIT,
        PF_STACK_BIT, PF_DATA_BIT, PF_INSTR_BIT, HF_VECTOR_BIT};
    pipe_model pipe (.clk_i(clk), .go_i(go), .idx_i(idx), .cause_o(cz));
    fault_sleep_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .cause_i(cz),
        .fault_addr_i(addr), .fault_addr_ok_i(1'b1), .handler_mode_i(hm), .in_hard_handler_i(hh),
        .exec_prio_i(ep), .wfi_i(ev[0]), .wfe_i(ev[1]), .handler_exit_i(ev[5]), .debug_wake_i(ev[4]),
        .pend_prio_i(pp), .pend_valid_i(pv), .new_pend_i(ev[3]), .mask_level_i(ml),
        .primary_interrupt_mask_i(pm), .fault_level_mask_i(fm), .send_event_i(ev[2]), .take_o(tk),
        .lockup_o(lock), .sleeping_o(slp), .deep_sleep_o(deep), .run_handler_o(rh));
    always #10 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    // Classic cycle, held until ack is sampled
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdata = dout;
        cyc <= 0; stb <= 0;
    endtask
    // Raise a cause; check the take pulse when one is expected
    task fire(input int i, input logic [3:0] e);
        @(posedge clk);
        go <= 1; idx <= i[3:0]; addr <= $random(seed);
        @(posedge clk);
        go <= 0;
        @(posedge clk);
        @(negedge clk);
        if (e[3]) chk(32'(tk), {28'h0, e});
    endtask
    task pulse(input int b);
        @(posedge clk);
        ev <= 6'h01 << b;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
    endtask
    task do_reset;
        rst <= 1;
        repeat (20) @(posedge clk);
        rst <= 0;
    endtask
    task wrap_up;
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        do_reset();
        wb(1, OFS_FAULT_CFG, 32'h0708_1010); // Handlers on, usage most urgent
        for (int i = 0; i < 16; i++) begin
            fire(i, {1'b1, 2'(i < 6 ? CLS_USAGE : i < 11 ? CLS_BUS : i < 15 ? CLS_PROT : CLS_HARD), 1'b0});
            wb(0, offs[i], 0);
            chk(rdata[bits[i]], 32'h1);
            if (i == 7 || i == 13) begin
                wb(0, i == 7 ? OFS_BUS_ADDR : OFS_PROT_ADDR, 0);
                chk(rdata, addr);
            end
            wb(1, offs[i], '1);
        end
        hm <= 1; ep <= 8'h10; // Handler running at level 10
        fire(0, {1'b1, 2'(CLS_USAGE), 1'b0});
        fire(7, {1'b1, 2'(CLS_HARD), 1'b1});
        wb(0, OFS_HARD_STATUS, 0);
        chk(rdata[HF_ESCAL_BIT], 32'h1);
        hm <= 0; wb(1, OFS_FAULT_CFG, 32'h0);
        fire(0, {1'b1, 2'(CLS_HARD), 1'b1});
        hm <= 1; hh <= 1; fire(15, 4'h0); repeat (4) @(negedge clk);
        chk(lock, 32'h1);
        hm <= 0; hh <= 0; do_reset(); @(negedge clk);
        chk(lock, 32'h0);
        wb(1, OFS_SYS_CTRL, 32'h14); @(negedge clk);
        chk(deep, 32'h1);
        pm <= 1; ml <= 8'h10; pp <= 8'h20; pv <= 1; // Pending but beneath the mask
        pulse(0); chk(slp, 32'h1);
        repeat (4) @(negedge clk); chk(slp, 32'h1);
        pp <= 8'h04; repeat (3) @(negedge clk); chk(slp, 32'h0);
        pv <= 0; pm <= 0; pulse(2); pulse(1); chk(slp, 32'h0);
        pulse(1); chk(slp, 32'h1);
        pulse(3); repeat (2) @(negedge clk); chk(slp, 32'h0);
        wb(1, OFS_SYS_CTRL, 32'h16); pulse(5); chk(slp, 32'h1);
        pulse(4); repeat (2) @(negedge clk); chk(slp, 32'h0);
        pulse(0); pulse(4); repeat (2) @(negedge clk); chk(slp, 32'h0);
        pv <= 1; pp <= 8'h04; fm <= 1; pulse(0); repeat (2) @(negedge clk); chk(slp, 32'h1);
        fm <= 0; @(negedge clk); chk(rh, 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- verification/pipe_model.sv ----
// Pipeline stand-in that raises one fault cause at a time
`timescale 1ns/10ps
`default_nettype none
module pipe_model
    import fault_sleep_pkg::*;
(
    input wire logic clk_i, // Core clock
    input wire logic go_i, // Fault request
    input wire logic [3:0] idx_i, // Cause bit, 0 = zero_div
    output fault_cause_s cause_o // One-cycle pulse
);
    // Registered, so the cause is a clean single-cycle pulse
    always_ff @(posedge clk_i) begin
        cause_o <= go_i ? fault_cause_s'(16'h0001 << idx_i) : '0;
    end
endmodule
`default_nettype wire
